// >>> osdwd_consts.vh
// Constants for the serial write decoder of the on-screen display.
`ifndef OSDWD_CONSTS_VH
`define OSDWD_CONSTS_VH
`define OSDWD_ROW_TAG 3'h4
`define OSDWD_ATTR_TAG 3'h5
`define OSDWD_SEG_TAG 2'h3
`define OSDWD_COL_EXPL 2'h0
`define OSDWD_COL_AUTO 2'h1
`define OSDWD_ROWS 5'h0F
`define OSDWD_COLS 5'h1E
`define OSDWD_ROW_LAST 4'hE
`define OSDWD_CTRL_ROW 4'hF
`define OSDWD_CTRL_COLS 5'h1C
`define OSDWD_ATTR_COL 5'h1E
`define OSDWD_RAM_GLYPHS 8'h08
`define OSDWD_DOT_MSB 4
`define OSDWD_BLINK_BIT 3
`define OSDWD_DBL_H_BIT 1
`define OSDWD_INTENS_BIT 2
`define OSDWD_DBL_W_BIT 0
`define OSDWD_BLINK_FRAMES 6'h28
`define OSDWD_FRAME_CTRL_COL 5'h0F
`define OSDWD_ENABLE_BIT 7
`define OSDWD_SEG_LAST 4'hF
`define OSDWD_LINE_LAST 4'hF
`endif

// >>> osdwd_decoder.v
// Serial write decoder for display, attribute, control and glyph memories.
`default_nettype none
`include "osdwd_consts.vh"
// Contract
// - 100 prefix selects display row.
// - 101 prefix selects attribute/control row.
// - 00X explicit column, 01X auto column.
// - 11 segment; line 00 explicit, 01 auto.
// - Explicit and same-row formats both decoded.
// - Auto format stores every following byte except those at display columns 30 and 31 or in display row 15.
// - Display memory is 15 by 30.
// - Entries are 8-bit glyph codes.
// - Codes 0-7 are RAM glyphs.
// - Glyph segment and line are 4 bits.
// - Glyph data keeps lower five bits.
// - Row attribute register at column 30.
// - Row 15 holds 28 control registers.
// - Double height row fills two screen rows.
// - Double width shows even columns only.
// - Each character has 3-bit colour.
// - Attribute bit 3 blinks character.
// - Bytes arrive from acknowledged serial receiver.
module osdwd_decoder #(
  parameter BLINK_FRAMES = `OSDWD_BLINK_FRAMES
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire byte_valid_in,
  output wire byte_ready_out,
  input wire [7:0] byte_data_in,
  input wire frame_start_in,
  input wire vsync_in,
  input wire [3:0] scr_row_in,
  input wire [4:0] scr_col_in,
  input wire [3:0] glyph_line_in,
  output reg [7:0] glyph_select_code_out,
  output reg [2:0] char_colour_out,
  output reg char_visible_out,
  output reg row_intensity_out,
  output reg [9:0] glyph_dots_out,
  output reg glyph_is_ram_out,
  output reg display_enable_bit_out,
  output reg [7:0] ctrl_data_out,
  input wire [4:0] ctrl_sel_in
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_AUTO = 2'h3;
  localparam AREA_DISP = 2'h0;
  localparam AREA_ATTR = 2'h1;
  localparam AREA_FONT = 2'h2;
  // Two-entry buffer in the byte path.
  reg [7:0] buf_q [0:1];
  reg [1:0] cnt_q;
  reg wp_q;
  reg rp_q;
  wire buf_out_valid = (cnt_q != 2'h0);
  wire [7:0] cur = buf_q[rp_q];
  wire take = buf_out_valid;
  wire push = byte_valid_in && (cnt_q != 2'h2);
  assign byte_ready_out = (cnt_q != 2'h2);
  reg [7:0] disp_mem [0:511];
  reg [3:0] attr_mem [0:511];
  wire [7:0] row_attr [0:15];
  reg [7:0] ctrl_reg [0:31];
  reg [4:0] font_mem [0:255];
  reg [1:0] st_q;
  reg [1:0] area_q;
  reg [3:0] row_q;
  reg [4:0] col_q;
  reg [3:0] vsync_s;
  reg [5:0] blink_cnt_q;
  reg blink_ph_q;
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q <= 2'h0;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wp_q <= ~wp_q;
      end
      if (take)
      begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, take};
    end
  end
  always @(posedge clk_in)
  begin
    if (push)
    begin
      buf_q[wp_q] <= byte_data_in;
    end
  end
  wire [8:0] waddr = {row_q, col_q};
  reg wr_data;
  always @*
  begin
    wr_data = take && ((st_q == ST_DATA) || (st_q == ST_AUTO));
  end
  wire row_attr_we = wr_data && area_q == AREA_ATTR
    && row_q <= `OSDWD_ROW_LAST && col_q == `OSDWD_ATTR_COL;
  // Row attributes reset to zero so the screen mapping is always defined.
  genvar g;
  generate
    for (g = 0; g <= `OSDWD_CTRL_ROW; g = g + 1)
    begin : g_row_attr
      localparam [3:0] IDX = g;
      reg [7:0] attr_q;
      always @(posedge clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
        begin
          attr_q <= 8'h00;
        end
        else if (row_attr_we && row_q == IDX)
        begin
          attr_q <= cur;
        end
      end
      assign row_attr[g] = attr_q;
    end
  endgenerate
  // Store one data byte into the selected area.
  always @(posedge clk_in)
  begin
    if (wr_data)
    begin
      if (area_q == AREA_DISP && row_q <= `OSDWD_ROW_LAST
          && col_q < `OSDWD_COLS)
      begin
        disp_mem[waddr] <= cur;
      end
      if (area_q == AREA_ATTR && row_q <= `OSDWD_ROW_LAST
          && col_q < `OSDWD_COLS)
      begin
        attr_mem[waddr] <= cur[3:0];
      end
      if (area_q == AREA_FONT)
      begin
        font_mem[{row_q, col_q[3:0]}] <= cur[`OSDWD_DOT_MSB:0];
      end
    end
  end
  // Control row registers and the display enable bit.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      display_enable_bit_out <= 1'b0;
    end
    else if (wr_data && area_q == AREA_ATTR && row_q == `OSDWD_CTRL_ROW
             && col_q == `OSDWD_FRAME_CTRL_COL)
    begin
      display_enable_bit_out <= cur[`OSDWD_ENABLE_BIT];
    end
  end
  always @(posedge clk_in)
  begin
    if (wr_data && area_q == AREA_ATTR && row_q == `OSDWD_CTRL_ROW
        && col_q < `OSDWD_CTRL_COLS)
    begin
      ctrl_reg[col_q] <= cur;
    end
    ctrl_data_out <= ctrl_reg[ctrl_sel_in];
  end
  // Byte classification state machine.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_q <= ST_IDLE;
      area_q <= AREA_DISP;
      row_q <= 4'h0;
      col_q <= 5'h00;
    end
    else if (frame_start_in)
    begin
      st_q <= ST_IDLE;
    end
    else if (take)
    begin
      case (st_q)
        ST_AUTO:
        begin
          // Advance one position; wrap to next row or segment.
          if ((area_q == AREA_FONT && col_q[3:0] == `OSDWD_LINE_LAST) ||
              (area_q != AREA_FONT && col_q == `OSDWD_ATTR_COL))
          begin
            col_q <= 5'h00;
            row_q <= row_q + 4'h1;
          end
          else
          begin
            col_q <= col_q + 5'h01;
          end
        end
        ST_DATA, ST_IDLE, ST_ADDR:
        begin
          if (st_q != ST_DATA && cur[7:5] == `OSDWD_ROW_TAG)
          begin
            area_q <= AREA_DISP;
            row_q <= cur[3:0];
            st_q <= ST_ADDR;
          end
          else if (st_q != ST_DATA && cur[7:5] == `OSDWD_ATTR_TAG)
          begin
            area_q <= AREA_ATTR;
            row_q <= cur[3:0];
            st_q <= ST_ADDR;
          end
          else if (st_q != ST_DATA && cur[7:6] == `OSDWD_SEG_TAG)
          begin
            area_q <= AREA_FONT;
            row_q <= cur[3:0];
            st_q <= ST_ADDR;
          end
          else if (st_q == ST_ADDR && cur[7:6] == `OSDWD_COL_AUTO)
          begin
            col_q <= (area_q == AREA_FONT) ? {1'b0, cur[3:0]} : cur[4:0];
            st_q <= ST_AUTO;
          end
          else if (st_q == ST_ADDR && cur[7:6] == `OSDWD_COL_EXPL)
          begin
            col_q <= (area_q == AREA_FONT) ? {1'b0, cur[3:0]} : cur[4:0];
            st_q <= ST_DATA;
          end
          else if (st_q == ST_DATA)
          begin
            st_q <= ST_ADDR;
          end
        end
        default:
        begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
  // Blink phase from vertical sync: about 1 Hz at 80 Hz scan.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      vsync_s <= 4'h0;
      blink_cnt_q <= 6'h00;
      blink_ph_q <= 1'b0;
    end
    else
    begin
      vsync_s <= {vsync_s[2:0], vsync_in};
      if (vsync_s[2] && !vsync_s[3])
      begin
        if (blink_cnt_q == BLINK_FRAMES[5:0] - 6'h01)
        begin
          blink_cnt_q <= 6'h00;
          blink_ph_q <= ~blink_ph_q;
        end
        else
        begin
          blink_cnt_q <= blink_cnt_q + 6'h01;
        end
      end
    end
  end
  // Screen to memory mapping for double height and width rows.
  reg [3:0] mrow;
  reg [3:0] srow;
  reg [4:0] mcol;
  reg [4:0] i;
  always @*
  begin
    mrow = 4'h0;
    srow = 4'h0;
    for (i = 5'h00; i < `OSDWD_ROWS; i = i + 5'h01)
    begin
      if (srow <= scr_row_in)
      begin
        mrow = i[3:0];
        srow = srow + (row_attr[i[3:0]][`OSDWD_DBL_H_BIT] ? 4'h2 : 4'h1);
      end
    end
    mcol = row_attr[mrow][`OSDWD_DBL_W_BIT] ? {scr_col_in[3:0], 1'b0}
                                            : scr_col_in;
  end
  wire [7:0] code_w = disp_mem[{mrow, mcol}];
  wire [3:0] attr_w = attr_mem[{mrow, mcol}];
  always @(posedge clk_in)
  begin
    glyph_select_code_out <= code_w;
    char_colour_out <= attr_w[2:0];
    char_visible_out <= !(attr_w[`OSDWD_BLINK_BIT] && blink_ph_q);
    row_intensity_out <= row_attr[mrow][`OSDWD_INTENS_BIT];
    glyph_is_ram_out <= code_w < `OSDWD_RAM_GLYPHS;
    glyph_dots_out <= {font_mem[{code_w[2:0], 1'b0, glyph_line_in}],
                       font_mem[{code_w[2:0], 1'b1, glyph_line_in}]};
  end
endmodule // osdwd_decoder
`default_nettype wire

// >>> osdwd_monitor.sv
// Concurrent checks on the ports of the serial write decoder.
`default_nettype none
module osdwd_monitor (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic byte_valid_in,
  input wire logic byte_ready_out,
  input wire logic [3:0] scr_row_in,
  input wire logic [4:0] scr_col_in,
  input wire logic [3:0] glyph_line_in,
  input wire logic [7:0] glyph_select_code_out,
  input wire logic [2:0] char_colour_out,
  input wire logic glyph_is_ram_out,
  input wire logic display_enable_bit_out,
  input wire logic [7:0] ctrl_data_out,
  input wire logic [4:0] ctrl_sel_in
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence quiet_s;
    !byte_valid_in && $stable(scr_row_in) && $stable(scr_col_in)
      && $stable(glyph_line_in);
  endsequence
  sequence sel_frame_s;
    (ctrl_sel_in == 5'h0F)[*3];
  endsequence
  a_ram_low: assert property (
    (glyph_select_code_out < 8'h08) |-> glyph_is_ram_out)
    else $error("Low code not flagged as programmable glyph.");
  a_rom_high: assert property (
    (glyph_select_code_out >= 8'h08) |-> !glyph_is_ram_out)
    else $error("High code flagged as programmable glyph.");
  a_enable_copy: assert property (
    sel_frame_s ##0 ctrl_data_out[7] |-> display_enable_bit_out)
    else $error("Enable bit disagrees with its control register.");
  a_ready_back: assert property (
    !byte_ready_out |-> ##[1:4] byte_ready_out)
    else $error("Byte buffer stays full.");
  a_ready_reset: assert property (
    $rose(rst_n_in) |-> byte_ready_out)
    else $error("Byte buffer not empty after reset.");
  a_enable_reset: assert property (
    $rose(rst_n_in) |-> !display_enable_bit_out)
    else $error("Display enabled after reset.");
  a_lookup_stands: assert property (
    quiet_s[*4] |-> $stable(glyph_select_code_out)
      && $stable(char_colour_out))
    else $error("Lookup output changed with no cause.");
  a_ctrl_stands: assert property (
    (!byte_valid_in && $stable(ctrl_sel_in))[*4]
      |-> $stable(ctrl_data_out))
    else $error("Control readback changed with no cause.");
endmodule // osdwd_monitor
bind osdwd_decoder osdwd_monitor mon (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .byte_valid_in(byte_valid_in),
  .byte_ready_out(byte_ready_out), .scr_row_in(scr_row_in),
  .scr_col_in(scr_col_in), .glyph_line_in(glyph_line_in),
  .glyph_select_code_out(glyph_select_code_out),
  .char_colour_out(char_colour_out), .glyph_is_ram_out(glyph_is_ram_out),
  .display_enable_bit_out(display_enable_bit_out),
  .ctrl_data_out(ctrl_data_out), .ctrl_sel_in(ctrl_sel_in));
`default_nettype wire

// >>> osdwd_host_model.sv
// Host controller model that hands received bytes to the decoder.
`default_nettype none
module osdwd_host_model (
  input wire logic clk_in,
  input wire logic byte_ready_in,
  output logic byte_valid_out,
  output logic [7:0] byte_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    byte_valid_out = 1'b0;
    byte_data_out = 8'hFF;
  end
  // Holds each byte until the decoder takes it.
  task automatic send(input logic [7:0] b);
    @(negedge clk_in);
    byte_valid_out = 1'b1;
    byte_data_out = b;
    @(posedge clk_in);
    while (byte_ready_in !== 1'b1) @(posedge clk_in);
  endtask
  // Released data shows the inverse of the last byte.
  task automatic idle;
    @(negedge clk_in);
    byte_valid_out = 1'b0;
    byte_data_out = ~byte_data_out;
  endtask
endmodule // osdwd_host_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the serial write decoder.
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic fs = 1'b0;
  logic vs = 1'b0;
  logic [3:0] row = 4'h0;
  logic [4:0] col = 5'h00;
  logic [3:0] line = 4'h0;
  logic [4:0] sel = 5'h00;
  logic valid, ready, ram, vis, inten, en;
  logic [7:0] data, code, ctrl;
  logic [2:0] colour;
  logic [9:0] dots;
  logic [7:0] exp_auto [0:2] = '{8'h10, 8'h85, 8'hC1};
  int failures = 0;
  int checks = 0;
  always #50 clk_in = ~clk_in;
  osdwd_host_model host (.clk_in(clk_in), .byte_ready_in(ready),
    .byte_valid_out(valid), .byte_data_out(data));
  osdwd_decoder #(.BLINK_FRAMES(2)) uut (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .byte_valid_in(valid), .byte_ready_out(ready),
    .byte_data_in(data), .frame_start_in(fs), .vsync_in(vs),
    .scr_row_in(row), .scr_col_in(col), .glyph_line_in(line),
    .glyph_select_code_out(code), .char_colour_out(colour),
    .char_visible_out(vis), .row_intensity_out(inten),
    .glyph_dots_out(dots), .glyph_is_ram_out(ram),
    .display_enable_bit_out(en), .ctrl_data_out(ctrl),
    .ctrl_sel_in(sel));
  // Sends one transmission, then a frame boundary.
  task automatic put(input logic [7:0] q[$]);
    foreach (q[i]) host.send(q[i]);
    host.idle();
    @(negedge clk_in) fs = 1'b1;
    @(negedge clk_in) fs = 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic look(input logic [3:0] r, input logic [4:0] c);
    @(negedge clk_in);
    row = r;
    col = c;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_in);
    failures++;
    summarize();
  end
  initial
  begin
    repeat (12) @(posedge clk_in);
    @(negedge clk_in) rst_n_in = 1'b1;
    put({8'h81, 8'h03, 8'h01, 8'h05, 8'h42});
    put({8'hA0, 8'h1E, 8'h00, 8'hA1, 8'h1E, 8'h00});
    put({8'hA1, 8'h03, 8'h05, 8'h05, 8'h0A});
    put({8'hC2, 8'h02, 8'hEA, 8'hC3, 8'h02, 8'hF5});
    @(negedge clk_in) line = 4'h2;
    look(4'h1, 5'h03);
    `CHK("code", 8'h01, code)
    `CHK("ram", 1'b1, ram)
    `CHK("colour", 3'h5, colour)
    `CHK("visible", 1'b1, vis)
    `CHK("dots", {5'h0A, 5'h15}, dots)
    look(4'h1, 5'h05);
    `CHK("code", 8'h42, code)
    `CHK("colour", 3'h2, colour)
    `CHK("visible", 1'b1, vis)
    repeat (2)
    begin
      @(negedge clk_in) vs = 1'b1;
      repeat (4) @(negedge clk_in);
      vs = 1'b0;
      repeat (4) @(negedge clk_in);
    end
    look(4'h1, 5'h05);
    `CHK("blink", 1'b0, vis)
    look(4'h1, 5'h03);
    `CHK("steady", 1'b1, vis)
    $display("explicit and same-row test done");
    put({8'hA2, 8'h1E, 8'h00, 8'hA3, 8'h5E, 8'h00, 8'h07});
    put({8'h82, 8'h4A, 8'h10, 8'h85, 8'hC1});
    for (int i = 0; i < 3; i++)
    begin
      look(4'h2, 5'h0A + 5'(i));
      `CHK("auto", exp_auto[i], code)
    end
    look(4'h4, 5'h00);
    `CHK("wrap", 3'h7, colour)
    $display("auto-increment test done");
    put({8'h80, 8'h04, 8'h55, 8'hA0, 8'h1E, 8'h07});
    look(4'h1, 5'h02);
    `CHK("double", 8'h55, code)
    `CHK("intensity", 1'b1, inten)
    look(4'h2, 5'h03);
    `CHK("next row", 8'h01, code)
    `CHK("intensity", 1'b0, inten)
    $display("double size test done");
    put({8'hAF, 8'h0F, 8'h80});
    @(negedge clk_in) sel = 5'h0F;
    repeat (3) @(negedge clk_in);
    `CHK("enable", 1'b1, en)
    `CHK("control", 8'h80, ctrl)
    $display("control row test done");
    summarize();
  end
endmodule // testbench
`default_nettype wire
